/* File: core/lspm_debounce.sv */
// one key: two-flop sync, stable-time filter, press pulse
module lspm_debounce #(
   parameter int STABLE_CYC = lspm_pkg::DEBOUNCE_CYC
) (
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic key_n,
   output logic      press
);
   logic        sync_a;   // first stage, read only by sync_b
   logic        sync_b;   // synchronised level
   logic        stable;   // filtered pressed level
   logic [23:0] cnt;      // stability counter

   // synchroniser for the raw pin
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end
      else
      begin
         sync_a <= ~key_n;
         sync_b <= sync_a;
      end
   end

   // accept a level only after it held still long enough; bounce restarts the count
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         stable <= 1'b0;
         cnt    <= '0;
         press  <= 1'b0;
      end
      else
      begin
         press <= 1'b0;
         if (sync_b == stable)
            cnt <= '0;
         else if (cnt >= 24'(STABLE_CYC - 1))
         begin
            stable <= sync_b;
            cnt    <= '0;
            press  <= sync_b; // one pulse per press, none on release
         end
         else
            cnt <= cnt + 24'h000001;
      end
   end
endmodule // lspm_debounce

/* File: core/lspm_pkg.sv */
package lspm_pkg;
   // apb register map, byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_POS      = 8'h08;
   localparam logic [7:0] ADDR_RPM      = 8'h0c;
   localparam logic [7:0] ADDR_FACTOR   = 8'h10;
   localparam logic [7:0] ADDR_OFFSET   = 8'h14;
   localparam logic [7:0] ADDR_RATE     = 8'h18;
   localparam logic [7:0] ADDR_DISPLAY  = 8'h1c;
   localparam logic [7:0] ADDR_LIM_BASE = 8'h20; // eight words, one per output
   // field positions
   localparam int CTRL_KEEP_BIT   = 0;
   localparam int LIM_OFF_LSB     = 16;
   // reset values, limits and glyph codes
   localparam logic [6:0] FACTOR_RST  = 7'h01;
   localparam logic [6:0] FACTOR_MAX  = 7'h64;
   localparam logic [8:0] ANGLE_MAX   = 9'h167;
   localparam logic [3:0] CHAN_RST    = 4'h1;
   localparam logic [3:0] CHAN_MAX    = 4'h8;
   localparam logic [11:0] DIGIT_SPLIT = 12'h3e8;
   localparam logic [3:0] GLYPH_BLANK = 4'hf;
   localparam logic [3:0] GLYPH_P     = 4'he;
   // timing
   localparam int CLK_HZ          = 100_000_000;
   localparam int TIMEOUT_S       = 60;
   localparam longint TIMEOUT_CYC = longint'(CLK_HZ) * TIMEOUT_S;
   localparam int DEBOUNCE_MS     = 10;
   localparam int DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;

   // main and sub modes, one-hot
   typedef enum logic [5:0] {
      LSPM_POS    = 6'b000001,
      LSPM_SPEED  = 6'b000010,
      LSPM_FACTOR = 6'b000100,
      LSPM_OFFSET = 6'b001000,
      LSPM_CHAN   = 6'b010000,
      LSPM_CHSUB  = 6'b100000
   } lspm_mode_t;

   // debounced one-cycle key strobes
   typedef struct packed {
      logic mode;
      logic arrow;
      logic raise;
      logic lower;
      logic recall;
   } lspm_keys_t;

   // display and indicator bundle
   typedef struct packed {
      logic [3:0]  left_glyph;
      logic [11:0] right_value;
      logic        led_pos;
      logic        led_speed;
      logic        led_offset;
      logic        led_chsub;
   } lspm_disp_t;
endpackage

/* File: core/lspm_top.sv */
// The implementer's own choices: the placing of the registers and the APB register port.
module lspm_top #(
   parameter longint TIMEOUT_CYC  = lspm_pkg::TIMEOUT_CYC,
   parameter int     DEBOUNCE_CYC = lspm_pkg::DEBOUNCE_CYC,
   parameter int     OUTPUTS      = 8
) (
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // panel pins, keys active low
   input  wire logic              panel_present_n,
   input  wire logic              key_mode_n,
   input  wire logic              key_arrow_n,
   input  wire logic              raise_key_n,
   input  wire logic              lower_key_n,
   input  wire logic              key_recall_n,
   input  wire logic              prog_permit_n,
   // shaft position 0..359 and measured speed, same clock
   input  wire logic [8:0]        shaft_angle,
   input  wire logic [11:0]       shaft_rpm,
   // nonvolatile default-mode bit, loaded at power-up
   input  wire logic              nv_default_speed,
   output logic                   nv_write,
   output logic                   nv_default_next,
   output logic [OUTPUTS-1:0]     limit_out,
   output lspm_pkg::lspm_disp_t   disp
);
   ////////////////////////////////////////////////////////////////////////////
   // key front end
   lspm_pkg::lspm_keys_t raw;     // debounced strobes before panel gating
   lspm_pkg::lspm_keys_t keys;    // strobes the mode logic acts on
   logic [4:0]           key_pins; // packed pins, order as the struct
   logic                 pres_a;   // panel detect sync stage one
   logic                 pres_b;   // panel detect synchronised
   logic                 perm_a;   // permit sync stage one
   logic                 perm_b;   // permit synchronised
   logic                 prog_ok;  // editing allowed

   assign key_pins = {key_mode_n, key_arrow_n, raise_key_n, lower_key_n, key_recall_n};

   // one debouncer per key
   genvar gk;
   generate
      for (gk = 0; gk < 5; gk++)
      begin : g_key
         lspm_debounce #(
            .STABLE_CYC (DEBOUNCE_CYC)
         ) u_deb (
            .sys_clk (sys_clk),
            .rstn    (rstn),
            .key_n   (key_pins[gk]),
            .press   (raw[gk])
         );
      end
   endgenerate

   // synchronise permit and panel presence
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pres_a <= 1'b0;
         pres_b <= 1'b0;
         perm_a <= 1'b0;
         perm_b <= 1'b0;
      end
      else
      begin
         pres_a <= ~panel_present_n;
         pres_b <= pres_a;
         perm_a <= ~prog_permit_n;
         perm_b <= perm_a;
      end
   end

   assign prog_ok = perm_b;
   // keys only count with a panel fitted; limit outputs never depend on it
   assign keys = pres_b ? raw : '0;

   ////////////////////////////////////////////////////////////////////////////
   // programmed values; held here, mirrored to nonvolatile store by software
   logic [6:0] factor;               // parts per revolution
   logic [8:0] offset;               // angle offset
   logic [3:0] chan;                 // selected channel, volatile
   logic [8:0] lim_on  [OUTPUTS];    // window start per output
   logic [8:0] lim_off [OUTPUTS];    // window end per output
   logic       dflt_speed;           // stored default mode
   logic       dflt_loaded;          // strap captured once

   lspm_pkg::lspm_mode_t mode;
   lspm_pkg::lspm_mode_t next_mode;
   logic                 editing;    // in a mode that alters values
   logic                 edit_try;   // raise or lower pressed
   logic                 any_key;
   logic                 timeout;
   logic [35:0]          idle_cnt;   // inactivity counter

   assign edit_try = keys.raise | keys.lower;
   assign any_key  = keys.mode | keys.arrow | keys.raise | keys.lower | keys.recall;
   assign editing  = (mode == lspm_pkg::LSPM_FACTOR) | (mode == lspm_pkg::LSPM_OFFSET)
                   | (mode == lspm_pkg::LSPM_CHAN) | (mode == lspm_pkg::LSPM_CHSUB);

   // capture the stored default once after reset release
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dflt_loaded <= 1'b0;
         dflt_speed  <= 1'b0;
      end
      else if (!dflt_loaded)
      begin
         dflt_loaded <= 1'b1;
         dflt_speed  <= nv_default_speed;
      end
      else if (keys.recall && mode == lspm_pkg::LSPM_POS && dflt_speed)
         dflt_speed <= 1'b0;
      else if (keys.recall && mode == lspm_pkg::LSPM_SPEED && !dflt_speed)
         dflt_speed <= 1'b1;
   end

   // nonvolatile write strobe whenever the default changes
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         nv_write        <= 1'b0;
         nv_default_next <= 1'b0;
      end
      else
      begin
         nv_write        <= dflt_loaded && keys.recall &&
                            ((mode == lspm_pkg::LSPM_POS && dflt_speed) ||
                             (mode == lspm_pkg::LSPM_SPEED && !dflt_speed));
         nv_default_next <= (mode == lspm_pkg::LSPM_SPEED);
      end
   end

   // inactivity timer, restarted by every press
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         idle_cnt <= '0;
      else if (any_key || !editing)
         idle_cnt <= '0;
      else if (!timeout)
         idle_cnt <= idle_cnt + 36'h000000001;
   end

   assign timeout = idle_cnt >= 36'(TIMEOUT_CYC - 1);

   ////////////////////////////////////////////////////////////////////////////
   // mode sequencer
   always_comb
   begin
      next_mode = mode;
      unique case (mode)
         lspm_pkg::LSPM_POS:
            if (keys.mode)
               next_mode = lspm_pkg::LSPM_SPEED;
         lspm_pkg::LSPM_SPEED:
            if (keys.mode)
               next_mode = lspm_pkg::LSPM_OFFSET;
            else if (keys.arrow)
               next_mode = lspm_pkg::LSPM_FACTOR;
         lspm_pkg::LSPM_FACTOR:
            if (keys.mode)
               next_mode = lspm_pkg::LSPM_OFFSET;
         lspm_pkg::LSPM_OFFSET:
            if (keys.mode)
               next_mode = lspm_pkg::LSPM_CHAN;
         lspm_pkg::LSPM_CHAN:
            if (keys.mode)
               next_mode = lspm_pkg::LSPM_POS;
            else if (keys.arrow)
               next_mode = lspm_pkg::LSPM_CHSUB;
         lspm_pkg::LSPM_CHSUB:
            if (keys.mode)
               next_mode = lspm_pkg::LSPM_POS;
         default:
            next_mode = lspm_pkg::LSPM_POS;
      endcase
      // a blocked edit attempt overrides the key's own move
      if (edit_try && !prog_ok && editing && mode != lspm_pkg::LSPM_CHAN)
         next_mode = lspm_pkg::LSPM_POS;
      if (timeout)
         next_mode = dflt_speed ? lspm_pkg::LSPM_SPEED : lspm_pkg::LSPM_POS;
   end

   // mode register; first cycle after reset lands on the stored default
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         mode <= lspm_pkg::LSPM_POS;
      else if (!dflt_loaded)
         mode <= nv_default_speed ? lspm_pkg::LSPM_SPEED : lspm_pkg::LSPM_POS;
      else
         mode <= next_mode;
   end

   ////////////////////////////////////////////////////////////////////////////
   // value editing; each strobe moves one step and applies at once
   logic apb_wr;                // completed apb write
   logic apb_rd;                // completed apb read
   logic [3:0] lim_idx;         // addressed output word

   assign apb_wr  = psel & penable & pwrite;
   assign apb_rd  = psel & penable & ~pwrite;
   assign lim_idx = 4'(paddr[7:2] - 6'(lspm_pkg::ADDR_LIM_BASE >> 2));

   // production-rate factor
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         factor <= lspm_pkg::FACTOR_RST;
      else if (mode == lspm_pkg::LSPM_FACTOR && prog_ok && keys.raise)
         factor <= (factor >= lspm_pkg::FACTOR_MAX) ? factor : factor + 7'h01;
      else if (mode == lspm_pkg::LSPM_FACTOR && prog_ok && keys.lower)
         factor <= (factor <= 7'h01) ? factor : factor - 7'h01;
      else if (apb_wr && paddr == lspm_pkg::ADDR_FACTOR)
      begin
         // software loads from nonvolatile store, clamped into range
         if (pwdata[6:0] == 7'h00)
            factor <= 7'h01;
         else if (pwdata[6:0] > lspm_pkg::FACTOR_MAX)
            factor <= lspm_pkg::FACTOR_MAX;
         else
            factor <= pwdata[6:0];
      end
   end

   // offset with wrap in both directions
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         offset <= '0;
      else if (mode == lspm_pkg::LSPM_OFFSET && prog_ok && keys.raise)
         offset <= (offset >= lspm_pkg::ANGLE_MAX) ? 9'h000 : offset + 9'h001;
      else if (mode == lspm_pkg::LSPM_OFFSET && prog_ok && keys.lower)
         offset <= (offset == 9'h000) ? lspm_pkg::ANGLE_MAX : offset - 9'h001;
      else if (apb_wr && paddr == lspm_pkg::ADDR_OFFSET && pwdata[8:0] <= lspm_pkg::ANGLE_MAX)
         offset <= pwdata[8:0];
   end

   // selected channel; volatile, selection needs no permit
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         chan <= lspm_pkg::CHAN_RST;
      else if (mode == lspm_pkg::LSPM_CHAN && keys.raise && chan < lspm_pkg::CHAN_MAX)
         chan <= chan + 4'h1;
      else if (mode == lspm_pkg::LSPM_CHAN && keys.lower && chan > 4'h1)
         chan <= chan - 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // limit windows and output compare
   logic [9:0] pos_sum;   // shaft plus offset, before wrap
   logic [8:0] position;  // machine position 0..359

   assign pos_sum  = {1'b0, shaft_angle} + {1'b0, offset};
   assign position = (pos_sum > {1'b0, lspm_pkg::ANGLE_MAX}) ? 9'(pos_sum - 10'h168)
                                                              : pos_sum[8:0];

   genvar go;
   generate
      for (go = 0; go < OUTPUTS; go++)
      begin : g_out
         // window limits, written by software from nonvolatile store
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               lim_on[go]  <= '0;
               lim_off[go] <= '0;
            end
            else if (apb_wr && paddr[7:5] == lspm_pkg::ADDR_LIM_BASE[7:5] &&
                     lim_idx == 4'(go))
            begin
               lim_on[go]  <= pwdata[8:0];
               lim_off[go] <= pwdata[lspm_pkg::LIM_OFF_LSB +: 9];
            end
         end

         // on inside [on, off); wraps through zero when off < on; equal means off
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
               limit_out[go] <= 1'b0;
            else if (lim_on[go] <= lim_off[go])
               limit_out[go] <= position >= lim_on[go] && position < lim_off[go];
            else
               limit_out[go] <= position >= lim_on[go] || position < lim_off[go];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // rate and display
   logic [18:0] rate_full;  // rpm times factor
   logic [11:0] rate;       // shown value, valid to 3999

   assign rate_full = shaft_rpm * factor;
   // above 3999 the reading is the operator's problem; we just truncate
   assign rate = rate_full[11:0];

   // display bundle per mode
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         disp <= '{lspm_pkg::GLYPH_BLANK, 12'h000, 1'b1, 1'b0, 1'b0, 1'b0};
      else
      begin
         disp            <= '{lspm_pkg::GLYPH_BLANK, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0};
         unique case (mode)
            lspm_pkg::LSPM_POS:
            begin
               disp.right_value <= {3'h0, position};
               disp.led_pos     <= 1'b1;
            end
            lspm_pkg::LSPM_SPEED:
            begin
               disp.right_value <= rate;
               disp.led_speed   <= 1'b1;
               if (rate > lspm_pkg::DIGIT_SPLIT)
                  disp.left_glyph <= 4'(rate / 12'h3e8);
            end
            lspm_pkg::LSPM_FACTOR:
            begin
               disp.left_glyph  <= lspm_pkg::GLYPH_P;
               disp.right_value <= {5'h00, factor};
            end
            lspm_pkg::LSPM_OFFSET:
            begin
               disp.right_value <= {3'h0, position};
               disp.led_offset  <= 1'b1;
            end
            lspm_pkg::LSPM_CHAN:
            begin
               disp.left_glyph  <= chan;
               disp.right_value <= {3'h0, lim_on[3'(chan - 4'h1)]};
            end
            lspm_pkg::LSPM_CHSUB:
            begin
               disp.left_glyph  <= chan;
               disp.right_value <= {3'h0, lim_on[3'(chan - 4'h1)]};
               disp.led_chsub   <= 1'b1;
            end
            default:
               disp.left_glyph <= lspm_pkg::GLYPH_BLANK;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, unmapped reads zero with pslverr
   logic mapped;  // address falls on a register

   assign pready = 1'b1;
   assign mapped = paddr[1:0] == 2'b00 && paddr <= lspm_pkg::ADDR_LIM_BASE + 8'h1c;

   // read data and error flag registered at the access edge
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         pslverr <= 1'b0;
         prdata  <= '0;
         if (!mapped)
            pslverr <= 1'b1;
         else if (paddr >= lspm_pkg::ADDR_LIM_BASE)
            prdata <= {7'h00, lim_off[3'(lim_idx)], 7'h00, lim_on[3'(lim_idx)]};
         else
            unique case (paddr)
               lspm_pkg::ADDR_CTRL:    prdata <= {31'h0, dflt_speed};
               lspm_pkg::ADDR_STATUS:  prdata <= {12'h0, chan, mode, prog_ok, pres_b,
                                                  limit_out};
               lspm_pkg::ADDR_POS:     prdata <= {23'h0, position};
               lspm_pkg::ADDR_RPM:     prdata <= {20'h0, shaft_rpm};
               lspm_pkg::ADDR_FACTOR:  prdata <= {25'h0, factor};
               lspm_pkg::ADDR_OFFSET:  prdata <= {23'h0, offset};
               lspm_pkg::ADDR_RATE:    prdata <= {13'h0, rate_full};
               default:                prdata <= {12'h0, disp.left_glyph, 4'h0,
                                                  disp.right_value};
            endcase
      end
   end
endmodule // lspm_top

/* File: verification/limit_switch_panel_mode_control_tb_top.sv */
module limit_switch_panel_mode_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int     DEB = 4;
   localparam longint TMO = 200;
   localparam int     KM = 4, KA = 3, KR = 2, KL = 1, KC = 0; // key bit per function
   localparam logic [31:0] FULL = 32'h000fffff, LG = 32'h000f000f, GL = 32'h000f0000;
   logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic        panel_n, permit_n, nv_def, nv_write, nv_next;
   logic [7:0]  paddr, limit_out;
   logic [31:0] pwdata, prdata;
   logic [4:0]  keys_n;
   logic [8:0]  angle;
   logic [11:0] rpm;
   lspm_pkg::lspm_disp_t disp;
   int          fails = 0, cmp_count = 0;
   logic [31:0] exq[$], mq[$]; // expected value and compare mask
   int          sq[$];         // which output to look at
   event        smp;
   logic [1:0]  nvs = '0;      // last store pulse: seen, value
   lspm_top #(.TIMEOUT_CYC(TMO), .DEBOUNCE_CYC(DEB)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .panel_present_n(panel_n),
      .key_mode_n(keys_n[KM]), .key_arrow_n(keys_n[KA]), .raise_key_n(keys_n[KR]),
      .lower_key_n(keys_n[KL]), .key_recall_n(keys_n[KC]), .prog_permit_n(permit_n),
      .shaft_angle(angle), .shaft_rpm(rpm), .nv_default_speed(nv_def), .nv_write(nv_write),
      .nv_default_next(nv_next), .limit_out(limit_out), .disp(disp));
   lspm_panel_model #(.HOLD_CYC(DEB + 6)) pm_u (.sys_clk(sys_clk), .keys_n(keys_n),
      .shaft_angle(angle), .shaft_rpm(rpm));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // the store strobe lasts one cycle, so keep what it carried
   always @(posedge sys_clk)
      if (nv_write)
         nvs <= {1'b1, nv_next};
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] dx(logic [3:0] g, logic [11:0] v, logic [3:0] l);
      lspm_pkg::lspm_disp_t t;
      t = {g, v, l};
      return 32'(t);
   endfunction
   function automatic logic [31:0] pick(int s);
      return s == 0 ? 32'(disp) : s == 1 ? prdata : s == 2 ? {24'h0, limit_out}
                    : {28'h0, nvs, pready, pslverr};
   endfunction
   task automatic cmp(logic [31:0] e, logic [31:0] m, logic [31:0] o);
      cmp_count++;
      if ((o & m) !== (e & m))
      begin
         fails++;
         $display("[FAIL] %0t expected %h got %h", $time, e & m, o & m);
      end
   endtask
   task automatic chk(logic [31:0] e, logic [31:0] m, int s);
      exq.push_back(e);
      mq.push_back(m);
      sq.push_back(s);
      ->smp;
   endtask
   // watcher: one step past the edge, so registered outputs have landed
   initial
      forever
      begin
         @(smp);
         #1;
         while (exq.size() > 0)
            cmp(exq.pop_front(), mq.pop_front(), pick(sq.pop_front()));
      end
   // one transfer; on a read d is the expected data
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] m);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
         @(posedge sys_clk);
      while (pready !== 1'b1);
      if (!w && m != 0)
         chk(d, m, 1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      #100us;
      fails++;
      test_done();
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, rstn, panel_n, permit_n, nv_def} = '0;
      void'($urandom(67));
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(dx(4'hf, 12'h02d, 4'h8), FULL, 0);
      pm_u.press(KM);
      chk(dx(4'hf, 12'h01e, 4'h4), FULL, 0);
      pm_u.press(KC);
      chk(32'he, 32'hf, 3);
      apb(1'b0, lspm_pkg::ADDR_CTRL, 32'h1, 32'h1);
      pm_u.press(KA);
      chk(dx(4'he, 12'h001, 4'h0), FULL, 0);
      pm_u.press(KR);
      chk(dx(4'he, 12'h002, 4'h0), FULL, 0);
      apb(1'b1, lspm_pkg::ADDR_FACTOR, 32'h64, 32'h0);
      pm_u.press(KR);
      chk(dx(4'he, 12'h064, 4'h0), FULL, 0);
      apb(1'b0, lspm_pkg::ADDR_RATE, 32'hbb8, '1);
      pm_u.press(KM);
      chk(dx(4'hf, 12'h000, 4'h2), LG, 0);
      pm_u.press(KL);
      apb(1'b0, lspm_pkg::ADDR_OFFSET, 32'h167, '1);
      apb(1'b0, lspm_pkg::ADDR_POS, 32'h2c, '1);
      pm_u.press(KR);
      apb(1'b0, lspm_pkg::ADDR_OFFSET, 32'h0, '1);
      pm_u.press(KM);
      chk(dx(4'h1, 12'h000, 4'h0), LG, 0);
      repeat (9) pm_u.press(KR);
      chk(dx(4'h8, 12'h000, 4'h0), LG, 0);
      repeat (9) pm_u.press(KL);
      chk(dx(4'h1, 12'h000, 4'h0), LG, 0);
      pm_u.press(KM);
      pm_u.press(KC);
      chk(32'ha, 32'hf, 3);
      apb(1'b0, lspm_pkg::ADDR_CTRL, 32'h0, 32'h1);
      pm_u.press(KM);
      chk(dx(4'h3, 12'h000, 4'h0), GL, 0);
      pm_u.press(KA);
      repeat (TMO + 40) @(posedge sys_clk);
      chk(dx(4'hf, 12'h02d, 4'h8), FULL, 0);
      permit_n <= 1'b1;
      pm_u.press(KM);
      pm_u.press(KA);
      pm_u.press(KR);
      chk(dx(4'hf, 12'h02d, 4'h8), FULL, 0);
      apb(1'b0, lspm_pkg::ADDR_FACTOR, 32'h64, '1);
      panel_n <= 1'b1;
      apb(1'b1, lspm_pkg::ADDR_LIM_BASE, 32'h0014000a, 32'h0);
      pm_u.set_shaft(9'h00a + 9'($urandom % 10));
      repeat (4) @(posedge sys_clk);
      chk(32'h1, 32'hff, 2);
      pm_u.set_shaft(9'h019);
      repeat (4) @(posedge sys_clk);
      chk(32'h0, 32'hff, 2);
      apb(1'b0, 8'h40, 32'h0, '1);
      chk(32'h3, 32'h3, 3);
      repeat (2) @(posedge sys_clk);
      test_done();
   end
endmodule // limit_switch_panel_mode_control_tb_top
bind lspm_top lspm_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) chk_u (
   .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .key_mode_n(key_mode_n), .key_arrow_n(key_arrow_n),
   .raise_key_n(raise_key_n), .lower_key_n(lower_key_n), .key_recall_n(key_recall_n),
   .nv_write(nv_write), .disp(disp));

/* File: verification/lspm_asserts.sv */
// panel checker: display layout, factor range, idle exit, bus answer
module lspm_asserts #(
   parameter longint TIMEOUT_CYC  = 200,
   parameter int     DEBOUNCE_CYC = 4
) (
   input wire logic                 sys_clk,
   input wire logic                 rstn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic [7:0]           paddr,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 key_mode_n,
   input wire logic                 key_arrow_n,
   input wire logic                 raise_key_n,
   input wire logic                 lower_key_n,
   input wire logic                 key_recall_n,
   input wire logic                 nv_write,
   input wire lspm_pkg::lspm_disp_t disp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] idle; // cycles since any key pin was low
   // counted from the last low level, later than the press pulse, so never early
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         idle <= '0;
      else if (!(key_mode_n && key_arrow_n && raise_key_n && lower_key_n && key_recall_n))
         idle <= '0;
      else if (idle != '1)
         idle <= idle + 32'h1;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_factor;
      disp.left_glyph == lspm_pkg::GLYPH_P;
   endsequence
   a_apb_ready: assert property (s_access |-> pready)
      else $error("access phase without ready");
   a_unmapped_err: assert property (psel && penable && paddr > 8'h3c |-> pslverr)
      else $error("unmapped access not flagged");
   a_nvwr_pulse: assert property (nv_write |=> !nv_write)
      else $error("store pulse longer than one cycle");
   a_factor_range: assert property (s_factor |-> disp.right_value inside {[12'h001:12'h064]})
      else $error("factor outside range");
   a_factor_dark: assert property (s_factor |-> !(disp.led_pos || disp.led_speed))
      else $error("led lit while editing factor");
   a_pos_layout: assert property (disp.led_pos |-> disp.left_glyph == lspm_pkg::GLYPH_BLANK
      && disp.right_value <= 12'h167)
      else $error("position layout wrong");
   a_chan_range: assert property (!disp.led_pos && !disp.led_speed && !disp.led_offset
      && disp.left_glyph != lspm_pkg::GLYPH_P |-> disp.left_glyph inside {[4'h1:4'h8]})
      else $error("channel outside range");
   a_one_led: assert property ($onehot0({disp.led_pos, disp.led_speed, disp.led_offset,
      disp.led_chsub}))
      else $error("several mode leds lit");
   a_speed_digit: assert property (disp.led_speed && disp.left_glyph == lspm_pkg::GLYPH_BLANK
      |-> disp.right_value <= lspm_pkg::DIGIT_SPLIT)
      else $error("large rate without left digit");
   a_idle_exit: assert property (idle > TIMEOUT_CYC + DEBOUNCE_CYC + 8 |-> not s_factor)
      else $error("editing mode kept past idle time");
endmodule // lspm_asserts

/* File: verification/lspm_panel_model.sv */
// operator keypad and resolver: clean presses, steady shaft
module lspm_panel_model #(
   parameter int HOLD_CYC = 10
) (
   input  wire logic   sys_clk,
   output logic [4:0]  keys_n,
   output logic [8:0]  shaft_angle,
   output logic [11:0] shaft_rpm
);
   timeunit 1ns;
   timeprecision 1ps;
   // rpm 30 times factor 100 stays under the rate ceiling
   initial
   begin
      keys_n = '1;
      shaft_angle = 9'h02d;
      shaft_rpm = 12'h01e;
   end
   // one press: low past the debounce span, then released as long
   task automatic press(input int k);
      @(posedge sys_clk);
      keys_n[k] <= 1'b0;
      repeat (HOLD_CYC) @(posedge sys_clk);
      keys_n[k] <= 1'b1;
      repeat (HOLD_CYC) @(posedge sys_clk);
   endtask
   task automatic set_shaft(input logic [8:0] a);
      @(posedge sys_clk);
      shaft_angle <= a;
   endtask
endmodule // lspm_panel_model
